/* pkg/dtp_pkg.sv */
// Package: register map, field positions, divider counts and state types of the dual timer
// Function
// - Clock-select bits 1:0 pick divide by 12, 4, 48 or external clock divided by 8.
// - Clock-select bit 3 clocks timer one from system clock, else prescaled clock.
// - Clock-select bit 2 clocks timer zero from system clock, else prescaled clock.
// - Clock-select bit 7 gives timer three high byte the system clock, else its own.
// - Clock-select bit 6 gives timer three (low byte) the system clock, else its own.
// - Clock-select bit 5 gives timer two high byte the system clock, else its own.
// - Clock-select bit 4 gives timer two (low byte) the system clock, else its own.
// - Each timer holds a 16-bit count, accessed as separate low and high bytes.
// - Mode 0 counts 13 bits: high byte plus low-byte bits 4 to 0.
// - Mode 0 wrap from 0x1FFF to 0x0000 sets the overflow flag.
// - Counter select counts count-pin falling edges, otherwise the selected internal clock.
// - Count only with run set and gate off or gate input at active level.
// - Setting run never clears or reloads the count; software preloads it.
// - Timer one mirrors timer zero with its own bits and gate input one.
// - Mode 1 counts all 16 bits and flags overflow on wrap to zero.
// - Mode 2 low byte counts, flags on wrap and reloads from the high byte.
// - Mode 3 timer zero low byte is an 8-bit counter with timer zero controls.
// - Mode 3 high byte counts internal clock, runs on timer one run, sets its flag.
// - In split mode timer one counts no pin edges and sets no flag; overflow still out.
// - In split mode timer one runs for mode field 0 to 2, stops for 3.
// - Overflow flag reaches the interrupt request only when its enable is set.
// - Mode codes: 00 13-bit, 01 16-bit, 10 reload, 11 split or inactive.
// - Flag clears on interrupt vectoring, and software may clear it by writing.
package dtp_pkg;
    localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h8E;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Run/flag register bit positions
    localparam int RF_TF1 = 7;
    localparam int RF_TR1 = 6;
    localparam int RF_TF0 = 5;
    localparam int RF_TR0 = 4;
    // Clock-select bit positions
    localparam int CK_T3H = 7;
    localparam int CK_T3L = 6;
    localparam int CK_T2H = 5;
    localparam int CK_T2L = 4;
    localparam int CK_T1 = 3;
    localparam int CK_T0 = 2;
    // Mode register bit positions
    localparam int MD_TIMER_ONE_GATE_ENABLE = 7;
    localparam int MD_CT1 = 6;
    localparam int MD_M1_LO = 4;
    localparam int MD_TIMER_ZERO_GATE_ENABLE = 3;
    localparam int MD_CT0 = 2;
    localparam int MD_M0_LO = 0;
    // Synchroniser lanes
    localparam int PIN_CNT0 = 0;
    localparam int PIN_CNT1 = 1;
    localparam int PIN_TIMER_ZERO_GATE_ENABLE = 2;
    localparam int PIN_TIMER_ONE_GATE_ENABLE = 3;
    localparam int PIN_XCLK = 4;
    localparam int SYS_DIV_12 = 12;
    localparam int SYS_DIV_4 = 4;
    localparam int SYS_DIV_48 = 48;
    localparam logic [2:0] XCLK_DIV_LAST = 3'h7;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } dtp_mode_e;

    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } dtp_cnt_s;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] lvl;
        logic [5:0] presc;
        logic [2:0] xdiv;
        logic [7:0] timer_clock_select;
        logic [7:0] timer_mode_register;
        logic tf1;
        logic tr1;
        logic tf0;
        logic tr0;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [7:0] rdata;
        logic t1_ovf;
    } dtp_state_s;

    // One count step of a timer in the given mode
    function automatic dtp_cnt_s dtp_step(input dtp_mode_e mode, input logic [7:0] hi,
                                          input logic [7:0] lo);
        dtp_cnt_s r;
        logic [12:0] v13;
        logic [15:0] v16;
        r = '{ovf: 1'b0, hi: hi, lo: lo};
        v13 = {hi, lo[4:0]} + 13'h0001;
        v16 = {hi, lo} + 16'h0001;
        unique case (mode)
            MODE_13BIT: begin
                r.ovf = ({hi, lo[4:0]} == 13'h1FFF);
                r.hi = v13[12:5];
                r.lo = {lo[7:5], v13[4:0]};
            end
            MODE_16BIT: begin
                r.ovf = ({hi, lo} == 16'hFFFF);
                r.hi = v16[15:8];
                r.lo = v16[7:0];
            end
            MODE_RELOAD: begin
                r.ovf = (lo == 8'hFF);
                r.lo = r.ovf ? hi : lo + 8'h01;
            end
            MODE_SPLIT: begin
                r.ovf = (lo == 8'hFF);
                r.lo = lo + 8'h01;
            end
        endcase
        return r;
    endfunction
endpackage

/* hdl/dtp_timer.sv */
// Module: dual timer with shared prescaler behind the special-function-register port
`timescale 1ns/1ns
module dtp_timer (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic COUNT_PIN_ZERO,
    input wire logic COUNT_PIN_ONE,
    input wire logic GATE_INPUT_ZERO,
    input wire logic GATE_INPUT_ONE,
    input wire logic EXT_CLOCK,
    input wire logic GATE_ZERO_POLARITY,
    input wire logic GATE_ONE_POLARITY,
    input wire logic TIMER_ZERO_IRQ_ENABLE,
    input wire logic TIMER_ONE_IRQ_ENABLE,
    input wire logic TIMER_ZERO_VECTOR_ACK,
    input wire logic TIMER_ONE_VECTOR_ACK,
    input wire logic TIMER_TWO_ALT_TICK,
    input wire logic TIMER_THREE_ALT_TICK,
    output logic TIMER_ZERO_IRQ,
    output logic TIMER_ONE_IRQ,
    output logic TIMER_ONE_OVERFLOW,
    output logic TIMER_TWO_LOW_TICK,
    output logic TIMER_TWO_HIGH_TICK,
    output logic TIMER_THREE_LOW_TICK,
    output logic TIMER_THREE_HIGH_TICK
);

    dtp_pkg::dtp_state_s st_r;
    dtp_pkg::dtp_state_s st_nxt;
    logic [4:0] fall;
    logic [4:0] rise;
    logic pre_tick;
    logic split;
    logic tick0;
    logic tick1;
    logic tick_hi;
    logic run0;
    logic run1;
    logic set0;
    logic set1;
    logic hi_ovf;
    logic ovf1;
    dtp_pkg::dtp_mode_e mode0;
    dtp_pkg::dtp_mode_e mode1;
    dtp_pkg::dtp_cnt_s c0;
    dtp_pkg::dtp_cnt_s c1;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        st_nxt = st_r;
        // Pin synchronisers; a level counts once the second and third stage agree
        st_nxt.s1 = {EXT_CLOCK, GATE_INPUT_ONE, GATE_INPUT_ZERO, COUNT_PIN_ONE, COUNT_PIN_ZERO};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 5; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s2[i];
            end
        end
        fall = st_r.lvl & ~st_nxt.lvl;
        rise = ~st_r.lvl & st_nxt.lvl;

        // Prescaler: a free down-counter; a change between internal codes takes effect at the next reload, a change to code 11 at once
        pre_tick = 1'b0;
        if (st_r.timer_clock_select[1:0] == 2'b11) begin
            if (rise[dtp_pkg::PIN_XCLK]) begin
                st_nxt.xdiv = st_r.xdiv + 3'h1;
                pre_tick = (st_r.xdiv == dtp_pkg::XCLK_DIV_LAST);
            end
        end else if (st_r.presc == 6'h00) begin
            pre_tick = 1'b1;
            unique case (st_r.timer_clock_select[1:0])
                2'b00: st_nxt.presc = 6'(dtp_pkg::SYS_DIV_12 - 1);
                2'b01: st_nxt.presc = 6'(dtp_pkg::SYS_DIV_4 - 1);
                default: st_nxt.presc = 6'(dtp_pkg::SYS_DIV_48 - 1);
            endcase
        end else begin
            st_nxt.presc = st_r.presc - 6'h01;
        end

        mode0 = dtp_pkg::dtp_mode_e'(st_r.timer_mode_register[dtp_pkg::MD_M0_LO +: 2]);
        mode1 = dtp_pkg::dtp_mode_e'(st_r.timer_mode_register[dtp_pkg::MD_M1_LO +: 2]);
        split = (mode0 == dtp_pkg::MODE_SPLIT);

        // Timer zero (low byte only in split mode)
        tick0 = st_r.timer_mode_register[dtp_pkg::MD_CT0] ? fall[dtp_pkg::PIN_CNT0]
              : (st_r.timer_clock_select[dtp_pkg::CK_T0] | pre_tick);
        run0 = st_r.tr0 & (~st_r.timer_mode_register[dtp_pkg::MD_TIMER_ZERO_GATE_ENABLE]
             | (st_r.lvl[dtp_pkg::PIN_TIMER_ZERO_GATE_ENABLE] == GATE_ZERO_POLARITY));
        c0 = dtp_pkg::dtp_step(mode0, st_r.th0, st_r.tl0);
        set0 = 1'b0;
        if (run0 && tick0) begin
            st_nxt.tl0 = c0.lo;
            if (!split) begin
                st_nxt.th0 = c0.hi;
            end
            set0 = c0.ovf;
        end

        // Split-mode high byte borrows timer one's run bit and flag
        tick_hi = st_r.timer_clock_select[dtp_pkg::CK_T0] | pre_tick;
        hi_ovf = split && st_r.tr1 && tick_hi && (st_r.th0 == 8'hFF);
        if (split && st_r.tr1 && tick_hi) begin
            st_nxt.th0 = st_r.th0 + 8'h01;
        end

        // Timer one; in split mode it runs on its mode field alone and never on pin edges
        tick1 = (st_r.timer_mode_register[dtp_pkg::MD_CT1] && !split) ? fall[dtp_pkg::PIN_CNT1]
              : (st_r.timer_clock_select[dtp_pkg::CK_T1] | pre_tick);
        if (split) begin
            run1 = (mode1 != dtp_pkg::MODE_SPLIT);
        end else begin
            run1 = st_r.tr1 && (mode1 != dtp_pkg::MODE_SPLIT)
                && (~st_r.timer_mode_register[dtp_pkg::MD_TIMER_ONE_GATE_ENABLE]
                | (st_r.lvl[dtp_pkg::PIN_TIMER_ONE_GATE_ENABLE] == GATE_ONE_POLARITY));
        end
        c1 = dtp_pkg::dtp_step(mode1, st_r.th1, st_r.tl1);
        ovf1 = 1'b0;
        if (run1 && tick1) begin
            st_nxt.tl1 = c1.lo;
            st_nxt.th1 = c1.hi;
            ovf1 = c1.ovf;
        end
        st_nxt.t1_ovf = ovf1;
        set1 = split ? hi_ovf : ovf1;

        // Register writes; a write to a count byte wins over that cycle's count
        if (SFR_WE) begin
            unique case (SFR_ADDR)
                dtp_pkg::ADDR_CLK_SEL: st_nxt.timer_clock_select = SFR_WDATA;
                dtp_pkg::ADDR_MODE: st_nxt.timer_mode_register = SFR_WDATA;
                dtp_pkg::ADDR_RUN_FLAG: begin
                    // Run bits only gate counting; the count is untouched
                    st_nxt.tf1 = SFR_WDATA[dtp_pkg::RF_TF1];
                    st_nxt.tr1 = SFR_WDATA[dtp_pkg::RF_TR1];
                    st_nxt.tf0 = SFR_WDATA[dtp_pkg::RF_TF0];
                    st_nxt.tr0 = SFR_WDATA[dtp_pkg::RF_TR0];
                end
                dtp_pkg::ADDR_T0_LOW: st_nxt.tl0 = SFR_WDATA;
                dtp_pkg::ADDR_T0_HIGH: st_nxt.th0 = SFR_WDATA;
                dtp_pkg::ADDR_T1_LOW: st_nxt.tl1 = SFR_WDATA;
                dtp_pkg::ADDR_T1_HIGH: st_nxt.th1 = SFR_WDATA;
                default: ;
            endcase
        end
        if (TIMER_ZERO_VECTOR_ACK) begin
            st_nxt.tf0 = 1'b0;
        end
        if (TIMER_ONE_VECTOR_ACK) begin
            st_nxt.tf1 = 1'b0;
        end
        // Hardware set wins over any clear in the same cycle
        if (set0) begin
            st_nxt.tf0 = 1'b1;
        end
        if (set1) begin
            st_nxt.tf1 = 1'b1;
        end

        if (SFR_RE) begin
            unique case (SFR_ADDR)
                dtp_pkg::ADDR_CLK_SEL: st_nxt.rdata = st_r.timer_clock_select;
                dtp_pkg::ADDR_MODE: st_nxt.rdata = st_r.timer_mode_register;
                dtp_pkg::ADDR_RUN_FLAG: st_nxt.rdata = {st_r.tf1, st_r.tr1, st_r.tf0, st_r.tr0, 4'h0};
                dtp_pkg::ADDR_T0_LOW: st_nxt.rdata = st_r.tl0;
                dtp_pkg::ADDR_T0_HIGH: st_nxt.rdata = st_r.th0;
                dtp_pkg::ADDR_T1_LOW: st_nxt.rdata = st_r.tl1;
                dtp_pkg::ADDR_T1_HIGH: st_nxt.rdata = st_r.th1;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign SFR_RDATA = st_r.rdata;
    assign TIMER_ZERO_IRQ = st_r.tf0 & TIMER_ZERO_IRQ_ENABLE;
    assign TIMER_ONE_IRQ = st_r.tf1 & TIMER_ONE_IRQ_ENABLE;
    assign TIMER_ONE_OVERFLOW = st_r.t1_ovf;
    // Count enables for the outer timers; a set bit means every system clock
    assign TIMER_TWO_LOW_TICK = st_r.timer_clock_select[dtp_pkg::CK_T2L] | TIMER_TWO_ALT_TICK;
    assign TIMER_TWO_HIGH_TICK = st_r.timer_clock_select[dtp_pkg::CK_T2H] | TIMER_TWO_ALT_TICK;
    assign TIMER_THREE_LOW_TICK = st_r.timer_clock_select[dtp_pkg::CK_T3L] | TIMER_THREE_ALT_TICK;
    assign TIMER_THREE_HIGH_TICK = st_r.timer_clock_select[dtp_pkg::CK_T3H] | TIMER_THREE_ALT_TICK;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    logic wr_t0;
    assign wr_t0 = SFR_WE && (SFR_ADDR == dtp_pkg::ADDR_T0_LOW || SFR_ADDR == dtp_pkg::ADDR_T0_HIGH);

    div_four_a: assert property (
        pre_tick && st_r.timer_clock_select[1:0] == 2'b01 ##1 (st_r.timer_clock_select[1:0] == 2'b01)[*4] |-> pre_tick)
        else $error("prescaler divide by 4 period wrong");
    div_twelve_a: assert property (
        pre_tick && st_r.timer_clock_select[1:0] == 2'b00 |=> !pre_tick [*8])
        else $error("prescaler divide by 12 ticked early");
    hold_stopped_a: assert property (
        !st_r.tr0 && !wr_t0 |=> st_r.tl0 == $past(st_r.tl0))
        else $error("stopped timer zero changed its count");
    run_keeps_a: assert property (
        // Split high byte runs on timer one's run bit, so only non-split mode is checked
        SFR_WE && SFR_ADDR == dtp_pkg::ADDR_RUN_FLAG && !st_r.tr0 && !run0 && !split
        |=> st_r.tl0 == $past(st_r.tl0) && st_r.th0 == $past(st_r.th0))
        else $error("setting run altered the count");
    wrap13_flag_a: assert property (
        mode0 == dtp_pkg::MODE_13BIT && run0 && tick0 && {st_r.th0, st_r.tl0[4:0]} == 13'h1FFF
        && !wr_t0 |=> st_r.tf0 && st_r.th0 == 8'h00 && st_r.tl0[4:0] == 5'h00)
        else $error("13-bit wrap did not flag");
    reload_a: assert property (
        mode0 == dtp_pkg::MODE_RELOAD && run0 && tick0 && st_r.tl0 == 8'hFF && !wr_t0
        |=> st_r.tl0 == $past(st_r.th0) && st_r.th0 == $past(st_r.th0) && st_r.tf0)
        else $error("reload mode wrap wrong");
    split_high_a: assert property (
        hi_ovf && !wr_t0 |=> st_r.tf1 && st_r.th0 == 8'h00)
        else $error("split high byte overflow lost");
    split_t1_quiet_a: assert property (
        split && !hi_ovf && !st_r.tf1 && !(SFR_WE && SFR_ADDR == dtp_pkg::ADDR_RUN_FLAG)
        |=> !st_r.tf1)
        else $error("timer one set its flag in split mode");
    vector_clear_a: assert property (
        TIMER_ZERO_VECTOR_ACK && !set0 |=> !st_r.tf0)
        else $error("vector acknowledge did not clear flag");
    irq_gate_a: assert property (
        !TIMER_ONE_IRQ_ENABLE |-> !TIMER_ONE_IRQ)
        else $error("interrupt raised while disabled");

    reload_seen_c: cover property (mode0 == dtp_pkg::MODE_RELOAD && set0);
    split_ovf_c: cover property (hi_ovf ##1 st_r.tf1);
    pin_count_c: cover property (st_r.timer_mode_register[dtp_pkg::MD_CT0] && run0 && fall[dtp_pkg::PIN_CNT0]);
    ext_presc_c: cover property (st_r.timer_clock_select[1:0] == 2'b11 && pre_tick);

endmodule // dtp_timer

/* tb/dtp_pins_model.sv */
// Model of the count pins, gate pins and external clock that face the timer block
`timescale 1ns/1ns
module dtp_pins_model (
    input wire logic clk,
    output logic cnt0,
    output logic cnt1,
    output logic timer_zero_gate_enable,
    output logic timer_one_gate_enable,
    output logic xclk
);
    logic xclk_on = 1'b0;
    initial begin
        cnt0 = 1'b1;
        cnt1 = 1'b1;
        timer_zero_gate_enable = 1'b1;
        timer_one_gate_enable = 1'b1;
        xclk = 1'b0;
    end
    // Period of six system clocks; held low when off so no stray prescaler edges appear
    always #30 xclk = xclk_on ? ~xclk : 1'b0;
    task automatic set_xclk(input logic on);
        xclk_on = on;
    endtask
    task automatic set_gate(input int idx, input logic v);
        if (idx == 0) timer_zero_gate_enable = v;
        else timer_one_gate_enable = v;
    endtask
    // Three cycles low and at least three high, above the two-cycle minimum
    task automatic pulse(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            if (idx == 0) cnt0 = 1'b0;
            else cnt1 = 1'b0;
            repeat (3) @(negedge clk);
            if (idx == 0) cnt0 = 1'b1;
            else cnt1 = 1'b1;
            repeat (3) @(negedge clk);
        end
    endtask
endmodule // dtp_pins_model

/* tb/tb_top.sv */
// Self-checking bench for the dual timer and prescaler block
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic c0, c1, g0, g1, xck;
    logic en0 = 1'b0;
    logic en1 = 1'b0;
    logic ack0 = 1'b0;
    logic ack1 = 1'b0;
    logic alt2 = 1'b0;
    logic alt3 = 1'b0;
    logic pol1 = 1'b0;
    logic irq0, irq1, ovf1, t2l, t2h, t3l, t3h;
    int n_fail = 0;
    int cmp_count = 0;
    always #5 mclk = ~mclk;
    dtp_pins_model pins (.clk(mclk), .cnt0(c0), .cnt1(c1), .timer_zero_gate_enable(g0), .timer_one_gate_enable(g1), .xclk(xck));
    dtp_timer i_dut (.MCLK(mclk), .ARST_N(arst_n), .SFR_ADDR(addr), .SFR_WE(we), .SFR_RE(re),
        .SFR_WDATA(wdata), .SFR_RDATA(rdata), .COUNT_PIN_ZERO(c0), .COUNT_PIN_ONE(c1),
        .GATE_INPUT_ZERO(g0), .GATE_INPUT_ONE(g1), .EXT_CLOCK(xck), .GATE_ZERO_POLARITY(1'b1),
        .GATE_ONE_POLARITY(pol1), .TIMER_ZERO_IRQ_ENABLE(en0), .TIMER_ONE_IRQ_ENABLE(en1),
        .TIMER_ZERO_VECTOR_ACK(ack0), .TIMER_ONE_VECTOR_ACK(ack1), .TIMER_TWO_ALT_TICK(alt2),
        .TIMER_THREE_ALT_TICK(alt3), .TIMER_ZERO_IRQ(irq0), .TIMER_ONE_IRQ(irq1),
        .TIMER_ONE_OVERFLOW(ovf1), .TIMER_TWO_LOW_TICK(t2l), .TIMER_TWO_HIGH_TICK(t2h),
        .TIMER_THREE_LOW_TICK(t3l), .TIMER_THREE_HIGH_TICK(t3h));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(negedge mclk);
        we <= 1'b0;
        @(negedge mclk);
    endtask
    // Two cycles each, so back-to-back reads stay evenly spaced
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        re <= 1'b1;
        @(negedge mclk);
        d = rdata;
        re <= 1'b0;
        @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] v;
        for (int a = 8'h88; a <= 8'h8F; a++) begin
            rd(a[7:0], v);
            chk(v, 8'h00);
        end
        wr(dtp_pkg::ADDR_CLK_SEL, 8'hA5);
        rd(dtp_pkg::ADDR_CLK_SEL, v);
        chk(v, 8'hA5);
        wr(dtp_pkg::ADDR_CLK_SEL, 8'h50);
        chk({4'h0, t3h, t3l, t2h, t2l}, 8'h05);
        alt2 <= 1'b1;
        alt3 <= 1'b1;
        @(negedge mclk);
        chk({4'h0, t3h, t3l, t2h, t2l}, 8'h0F);
        alt2 <= 1'b0;
        alt3 <= 1'b0;
        wr(dtp_pkg::ADDR_CLK_SEL, 8'hA0);
        chk({4'h0, t3h, t3l, t2h, t2l}, 8'h0A);
        wr(dtp_pkg::ADDR_CLK_SEL, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_mode0();
        logic [7:0] v;
        wr(dtp_pkg::ADDR_MODE, 8'h04);
        wr(dtp_pkg::ADDR_T0_HIGH, 8'hFF);
        wr(dtp_pkg::ADDR_T0_LOW, 8'hFE);
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h10);
        repeat (8) @(negedge mclk);
        rd(dtp_pkg::ADDR_T0_LOW, v);
        chk(v, 8'hFE);
        pins.pulse(0, 2);
        repeat (4) @(negedge mclk);
        rd(dtp_pkg::ADDR_T0_LOW, v);
        chk(v, 8'hE0);
        rd(dtp_pkg::ADDR_T0_HIGH, v);
        chk(v, 8'h00);
        rd(dtp_pkg::ADDR_RUN_FLAG, v);
        chk(v, 8'h30);
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h00);
        rd(dtp_pkg::ADDR_RUN_FLAG, v);
        chk(v, 8'h00);
        $display("test mode0 done");
    endtask
    task automatic t_mode2();
        logic [7:0] v;
        wr(dtp_pkg::ADDR_MODE, 8'h06);
        wr(dtp_pkg::ADDR_T0_HIGH, 8'h10);
        wr(dtp_pkg::ADDR_T0_LOW, 8'hFE);
        en0 <= 1'b1;
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h10);
        pins.pulse(0, 3);
        repeat (4) @(negedge mclk);
        rd(dtp_pkg::ADDR_T0_LOW, v);
        chk(v, 8'h11);
        rd(dtp_pkg::ADDR_T0_HIGH, v);
        chk(v, 8'h10);
        chk({7'h00, irq0}, 8'h01);
        en0 <= 1'b0;
        @(negedge mclk);
        chk({7'h00, irq0}, 8'h00);
        en0 <= 1'b1;
        ack0 <= 1'b1;
        @(negedge mclk);
        ack0 <= 1'b0;
        @(negedge mclk);
        chk({7'h00, irq0}, 8'h00);
        rd(dtp_pkg::ADDR_RUN_FLAG, v);
        chk(v, 8'h10);
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h00);
        en0 <= 1'b0;
        $display("test mode2 done");
    endtask
    task automatic t_gate();
        logic [7:0] v;
        wr(dtp_pkg::ADDR_MODE, 8'hD0);
        wr(dtp_pkg::ADDR_T1_HIGH, 8'hFF);
        wr(dtp_pkg::ADDR_T1_LOW, 8'hFE);
        en1 <= 1'b1;
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h40);
        pins.pulse(1, 2);
        repeat (4) @(negedge mclk);
        rd(dtp_pkg::ADDR_T1_LOW, v);
        chk(v, 8'hFE);
        pins.set_gate(1, 1'b0);
        repeat (4) @(negedge mclk);
        pins.pulse(1, 2);
        repeat (4) @(negedge mclk);
        rd(dtp_pkg::ADDR_T1_LOW, v);
        chk(v, 8'h00);
        rd(dtp_pkg::ADDR_T1_HIGH, v);
        chk(v, 8'h00);
        rd(dtp_pkg::ADDR_RUN_FLAG, v);
        chk(v, 8'hC0);
        chk({7'h00, irq1}, 8'h01);
        ack1 <= 1'b1;
        @(negedge mclk);
        ack1 <= 1'b0;
        @(negedge mclk);
        chk({7'h00, irq1}, 8'h00);
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h00);
        pins.set_gate(1, 1'b1);
        en1 <= 1'b0;
        $display("test gate done");
    endtask
    // Count gained over exactly 480 cycles for each clock choice
    task automatic t_presc();
        logic [7:0] a0, a1, b0, b1;
        logic [7:0] ck [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08};
        logic [7:0] e0 [6] = '{8'h28, 8'h78, 8'h0A, 8'h0A, 8'hE0, 8'h28};
        logic [7:0] e1 [6] = '{8'h28, 8'h78, 8'h0A, 8'h0A, 8'h28, 8'hE0};
        pins.set_xclk(1'b1);
        wr(dtp_pkg::ADDR_MODE, 8'h11);
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h50);
        for (int i = 0; i < 6; i++) begin
            wr(dtp_pkg::ADDR_CLK_SEL, ck[i]);
            repeat (100) @(negedge mclk);
            rd(dtp_pkg::ADDR_T0_LOW, a0);
            rd(dtp_pkg::ADDR_T1_LOW, a1);
            repeat (476) @(negedge mclk);
            rd(dtp_pkg::ADDR_T0_LOW, b0);
            rd(dtp_pkg::ADDR_T1_LOW, b1);
            chk(b0 - a0, e0[i]);
            chk(b1 - a1, e1[i]);
        end
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h00);
        pins.set_xclk(1'b0);
        $display("test prescaler done");
    endtask
    task automatic t_split();
        logic [7:0] v;
        int k;
        wr(dtp_pkg::ADDR_CLK_SEL, 8'h0C);
        wr(dtp_pkg::ADDR_T1_HIGH, 8'hFF);
        wr(dtp_pkg::ADDR_T1_LOW, 8'hF0);
        wr(dtp_pkg::ADDR_T0_LOW, 8'h00);
        wr(dtp_pkg::ADDR_T0_HIGH, 8'h00);
        wr(dtp_pkg::ADDR_MODE, 8'h13);
        for (k = 0; k < 80 && ovf1 !== 1'b1; k++) @(negedge mclk);
        chk({7'h00, ovf1}, 8'h01);
        if (ovf1 !== 1'b1) stop_test();
        rd(dtp_pkg::ADDR_RUN_FLAG, v);
        chk(v, 8'h00);
        rd(dtp_pkg::ADDR_T0_HIGH, v);
        chk(v, 8'h00);
        wr(dtp_pkg::ADDR_T0_HIGH, 8'hFE);
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h40);
        repeat (4) @(negedge mclk);
        rd(dtp_pkg::ADDR_RUN_FLAG, v);
        chk(v, 8'hC0);
        rd(dtp_pkg::ADDR_T0_LOW, v);
        chk(v, 8'h00);
        wr(dtp_pkg::ADDR_RUN_FLAG, 8'h00);
        wr(dtp_pkg::ADDR_MODE, 8'h33);
        wr(dtp_pkg::ADDR_T1_LOW, 8'h55);
        repeat (20) @(negedge mclk);
        rd(dtp_pkg::ADDR_T1_LOW, v);
        chk(v, 8'h55);
        wr(dtp_pkg::ADDR_MODE, 8'h00);
        $display("test split done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
        t_regs();
        t_mode0();
        t_mode2();
        t_gate();
        t_presc();
        t_split();
        stop_test();
    end
endmodule // tb_top
